// ===== hw/rot_pkg.sv
package rot_pkg;
   // ----------------------------------------
   // opcode field positions
   // ----------------------------------------
   localparam int unsigned CNT_MSB     = 11;
   localparam int unsigned CNT_LSB     = 9;
   localparam int unsigned DIR_BIT     = 8;
   localparam int unsigned SIZE_MSB    = 7;
   localparam int unsigned SIZE_LSB    = 6;
   localparam int unsigned IR_BIT      = 5;
   localparam int unsigned RTYPE_MSB   = 4;
   localparam int unsigned RTYPE_LSB   = 3;
   localparam int unsigned MTYPE_MSB   = 10;
   localparam int unsigned MTYPE_LSB   = 9;
   localparam int unsigned MODE_MSB    = 5;
   localparam int unsigned MODE_LSB    = 3;
   localparam int unsigned EAREG_MSB   = 2;
   localparam int unsigned EAREG_LSB   = 0;
   localparam int unsigned GROUP_MSB   = 15;
   localparam int unsigned GROUP_LSB   = 12;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [3:0] GROUP_SHIFT  = 4'hE;
   localparam logic [1:0] TYPE_PLAIN   = 2'h3;
   localparam logic [1:0] TYPE_EXTEND  = 2'h2;
   localparam logic [1:0] SIZE_BYTE    = 2'h0;
   localparam logic [1:0] SIZE_WORD    = 2'h1;
   localparam logic [1:0] SIZE_LONG    = 2'h2;
   localparam logic [1:0] SIZE_MEMORY  = 2'h3;
   localparam logic [2:0] MODE_MIN_MEM = 3'h2;
   localparam logic [2:0] MODE_MAX_AN  = 3'h6;
   localparam logic [2:0] MODE_ABS     = 3'h7;
   localparam logic [2:0] ABS_SHORT    = 3'h0;
   localparam logic [2:0] ABS_LONG     = 3'h1;
   localparam logic [5:0] IMM_ZERO_CNT = 6'h08;
   localparam logic [5:0] MEM_CNT      = 6'h01;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] RESULT_RST  = 32'h0000_0000;
   localparam logic [4:0]  CCB_RST     = 5'h00;
   // condition code bit positions
   localparam int unsigned CC_C = 0;
   localparam int unsigned CC_V = 1;
   localparam int unsigned CC_Z = 2;
   localparam int unsigned CC_N = 3;
   localparam int unsigned CC_X = 4;
endpackage

// ===== hw/rot_core.sv
`timescale 1ns/1ps
// combinational rotate of up to 32 bits, optionally through extend
module rot_core
   import rot_pkg::*;
(
   input  wire logic [31:0] operand,
   input  wire logic [1:0]  sizeSel,
   input  wire logic        toLeft,
   input  wire logic        withExtend,
   input  wire logic        extendIn,
   input  wire logic [5:0]  count,
   output logic      [31:0] result,
   output logic             lastOut
);
   // ----------------------------------------
   // one bit step at a time, up to 63 steps
   // ----------------------------------------
   always_comb begin
      logic [31:0] v;
      logic        x;
      logic        msb;
      logic        lsb;
      int unsigned w;
      msb     = 1'b0;
      lsb     = 1'b0;
      v       = operand;
      x       = extendIn;
      lastOut = 1'b0;
      w       = (sizeSel == SIZE_BYTE) ? 8 : (sizeSel == SIZE_LONG) ? 32 : 16;
      for (int i = 0; i < 64; i++) begin
         if (i < int'(count)) begin
            msb = v[w-1];
            lsb = v[0];
            if (toLeft) begin
               v       = {v[30:0], (withExtend ? x : msb)};
               lastOut = msb;
               x       = msb;
            end else begin
               v       = {1'b0, v[31:1]};
               v[w-1]  = withExtend ? x : lsb;
               lastOut = lsb;
               x       = lsb;
            end
            // confine to sized field
            if (w == 8) begin
               v[31:8] = operand[31:8];
            end else if (w == 16) begin
               v[31:16] = operand[31:16];
            end
         end
      end
      result = v;
   end
endmodule

// ===== hw/rot_unit.sv
`timescale 1ns/1ps
// What this block does
// - immediate count field 1-7 gives that count, 0 gives eight
// - register count uses that register value modulo 64
// - count-source bit clear means immediate, set means register count
// - direction bit zero rotates right, one rotates left
// - size 00 byte, 01 word, 10 long; rotate only those low bits
// - low register field selects the rotated and written-back data register
// - memory form rotates one bit on a 16-bit word only
// - memory form accepts only memory-alterable address modes
// - plain left: msb goes to carry and into lsb
// - plain right: lsb goes to carry and into msb
// - plain rotates leave extend unchanged and outside the chain
// - plain: negative from msb, zero on zero result, overflow cleared
// - plain: carry is last bit out, cleared on zero count
// - extend left: msb to carry and extend, old extend into lsb
// - extend right: lsb to carry and extend, old extend into msb
// - extend rotate sets extend to last bit out, kept on zero count
// - extend rotate carry is last bit out, or extend on zero count
module rot_unit
   import rot_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        start,
   input  wire logic [15:0] opcode,
   input  wire logic [31:0] operand,
   input  wire logic [31:0] countReg,
   input  wire logic [4:0]  ccbIn,
   output logic             done,
   output logic             illegal,
   output logic [31:0]      result,
   output logic             writeReg,
   output logic [2:0]       destReg,
   output logic [2:0]       countRegSel,
   output logic [4:0]       condition_code_byte
);
   import rot_pkg::*;

   typedef enum logic [1:0] {
      RT_NONE   = 2'b00,
      RT_PLAIN  = 2'b01,
      RT_EXTEND = 2'b10
   } rot_kind_t;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic mem_alterable(input logic [2:0] mode, input logic [2:0] reg_no);
      mem_alterable = ((mode >= MODE_MIN_MEM) && (mode <= MODE_MAX_AN)) ||
                      ((mode == MODE_ABS) && ((reg_no == ABS_SHORT) || (reg_no == ABS_LONG)));
   endfunction

   function automatic rot_kind_t kind_of(input logic [1:0] bits);
      if (bits == TYPE_PLAIN) begin
         kind_of = RT_PLAIN;
      end else if (bits == TYPE_EXTEND) begin
         kind_of = RT_EXTEND;
      end else begin
         kind_of = RT_NONE;
      end
   endfunction

   // top bit of the sized field
   function automatic logic sized_msb(input logic [31:0] value, input logic [1:0] size);
      if (size == SIZE_BYTE) begin
         sized_msb = value[7];
      end else if (size == SIZE_LONG) begin
         sized_msb = value[31];
      end else begin
         sized_msb = value[15];
      end
   endfunction

   // sized field all zeros
   function automatic logic sized_zero(input logic [31:0] value, input logic [1:0] size);
      if (size == SIZE_BYTE) begin
         sized_zero = (value[7:0] == 8'h00);
      end else if (size == SIZE_LONG) begin
         sized_zero = (value == 32'h0000_0000);
      end else begin
         sized_zero = (value[15:0] == 16'h0000);
      end
   endfunction

   logic      isMem;
   logic      leftDir;
   rot_kind_t kind;
   logic      eaOk;
   logic [5:0] effCount;
   logic [1:0] effSize;
   logic [2:0] cntField;

   // form, direction and kind selection
   always_comb begin
      isMem    = (opcode[SIZE_MSB:SIZE_LSB] == SIZE_MEMORY);
      leftDir  = opcode[DIR_BIT];
      cntField = opcode[CNT_MSB:CNT_LSB];
      if (isMem) begin
         kind    = kind_of(opcode[MTYPE_MSB:MTYPE_LSB]);
         eaOk    = mem_alterable(opcode[MODE_MSB:MODE_LSB], opcode[EAREG_MSB:EAREG_LSB]);
         effCount = MEM_CNT;
         effSize  = SIZE_WORD;
      end else begin
         kind    = kind_of(opcode[RTYPE_MSB:RTYPE_LSB]);
         eaOk    = 1'b1;
         effSize = opcode[SIZE_MSB:SIZE_LSB];
         if (opcode[IR_BIT]) begin
            effCount = countReg[5:0];
         end else if (cntField == 3'h0) begin
            effCount = IMM_ZERO_CNT;
         end else begin
            effCount = {3'h0, cntField};
         end
      end
   end

   // ----------------------------------------
   // datapath
   // ----------------------------------------
   logic [31:0] rotated;
   logic        lastOut;

   rot_core u_core (
      .operand    (operand),
      .sizeSel    (effSize),
      .toLeft     (leftDir),
      .withExtend (kind == RT_EXTEND),
      .extendIn   (ccbIn[CC_X]),
      .count      (effCount),
      .result     (rotated),
      .lastOut    (lastOut)
   );

   // ----------------------------------------
   // handshake outputs
   // ----------------------------------------
   // a refused op still pulses done, with illegal beside it
   logic        refuse;
   logic        next_done;
   logic        next_illegal;
   logic        next_writeReg;
   logic [2:0]  next_destReg;
   logic [2:0]  next_countRegSel;

   // refusal decode and handshake next values
   always_comb begin
      refuse           = (opcode[GROUP_MSB:GROUP_LSB] != GROUP_SHIFT) || (kind == RT_NONE) || !eaOk;
      next_done        = start;
      next_illegal     = start && refuse;
      next_writeReg    = start && !refuse && !isMem;
      next_destReg     = destReg;
      next_countRegSel = opcode[CNT_MSB:CNT_LSB];
      if (start && !refuse) begin
         next_destReg = opcode[EAREG_MSB:EAREG_LSB];
      end
   end

   // register the handshake outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done        <= 1'b0;
         illegal     <= 1'b0;
         writeReg    <= 1'b0;
         destReg     <= 3'h0;
         countRegSel <= 3'h0;
      end else begin
         done        <= next_done;
         illegal     <= next_illegal;
         writeReg    <= next_writeReg;
         destReg     <= next_destReg;
         countRegSel <= next_countRegSel;
      end
   end

   // ----------------------------------------
   // result and condition code byte
   // ----------------------------------------
   logic [31:0] next_result;
   logic [4:0]  next_ccb;
   logic        resMsb;
   logic        resZero;

   // result and flags next values; refused ops only copy the incoming flags
   always_comb begin
      next_result = result;
      next_ccb    = condition_code_byte;
      resMsb      = sized_msb(rotated, effSize);
      resZero     = sized_zero(rotated, effSize);
      if (start) begin
         next_ccb = ccbIn;
         if (!refuse) begin
            next_result    = rotated;
            next_ccb[CC_N] = resMsb;
            next_ccb[CC_Z] = resZero;
            next_ccb[CC_V] = 1'b0;
            // zero count: plain clears carry, extend copies extend into carry
            if (kind == RT_PLAIN) begin
               next_ccb[CC_C] = (effCount == 6'h00) ? 1'b0 : lastOut;
            end else if (effCount == 6'h00) begin
               next_ccb[CC_C] = ccbIn[CC_X];
            end else begin
               next_ccb[CC_C] = lastOut;
               next_ccb[CC_X] = lastOut;
            end
         end
      end
   end

   // register the result and flags; result held until the next accepted op, flags until the next start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         result              <= RESULT_RST;
         condition_code_byte <= CCB_RST;
      end else begin
         result              <= next_result;
         condition_code_byte <= next_ccb;
      end
   end
endmodule

// ===== dv/rot_seq_model.sv
`timescale 1ns/1ps
// sequencer side: data registers, count source and write-back
module rot_seq_model (
   input  wire logic        clk,
   input  wire logic [15:0] opcode,
   input  wire logic        loadEn,
   input  wire logic [31:0] loadVal,
   input  wire logic        wrEn,
   input  wire logic [2:0]  wrSel,
   input  wire logic [31:0] wrData,
   output logic      [31:0] countReg
);
   logic [31:0] dreg [8];
   // register named by the count field, shown in the start cycle
   assign countReg = dreg[opcode[11:9]];
   // preload from the bench, write-back from the unit
   always @(posedge clk) begin
      if (loadEn) dreg[opcode[11:9]] <= loadVal;
      if (wrEn) dreg[wrSel] <= wrData;
   end
endmodule

// ===== dv/rot_unit_assertions.sv
`timescale 1ns/1ps
module rot_unit_assertions
   import rot_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        start,
   input wire logic [15:0] opcode,
   input wire logic [31:0] operand,
   input wire logic [31:0] countReg,
   input wire logic [4:0]  ccbIn,
   input wire logic        done,
   input wire logic        illegal,
   input wire logic [31:0] result,
   input wire logic        writeReg,
   input wire logic [2:0]  destReg,
   input wire logic [2:0]  countRegSel,
   input wire logic [4:0]  condition_code_byte
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // register form decode helpers
   logic regPlain, regExt, leftImm;
   assign regPlain = opcode[15:12] == GROUP_SHIFT && opcode[7:6] != SIZE_MEMORY && opcode[4:3] == TYPE_PLAIN;
   assign regExt   = opcode[15:12] == GROUP_SHIFT && opcode[7:6] != SIZE_MEMORY && opcode[4:3] == TYPE_EXTEND;
   assign leftImm  = regPlain && opcode[DIR_BIT] && !opcode[IR_BIT];
   done_timing_a: assert property (done == $past(start)) else $error("done not one cycle after start");
   illegal_copy_a: assert property (illegal |-> condition_code_byte == $past(ccbIn) && !writeReg)
      else $error("refused op changed flags");
   mode_reject_a: assert property (start && opcode[15:12] == GROUP_SHIFT && opcode[7:6] == SIZE_MEMORY
      && opcode[5:3] < MODE_MIN_MEM |=> illegal) else $error("bad memory mode accepted");
   dest_reg_a: assert property (writeReg |-> destReg == $past(opcode[2:0]) && !illegal)
      else $error("wrong write-back register");
   mem_noreg_a: assert property (start && opcode[7:6] == SIZE_MEMORY |=> !writeReg)
      else $error("memory form wrote a register");
   vflag_clear_a: assert property (done && !illegal |-> !condition_code_byte[CC_V]) else $error("V set");
   plain_keepx_a: assert property (start && regPlain |=> condition_code_byte[CC_X] == $past(ccbIn[CC_X]))
      else $error("plain rotate changed X");
   extend_cx_a: assert property (done && $past(regExt) |->
      condition_code_byte[CC_C] == condition_code_byte[CC_X]) else $error("extend rotate C differs from X");
   left_carry_a: assert property (done && $past(leftImm) |-> condition_code_byte[CC_C] == result[0])
      else $error("left carry not lsb");
   zero_count_a: assert property (start && regPlain && opcode[IR_BIT] && countReg[5:0] == 6'h00
      |=> !condition_code_byte[CC_C] && result == $past(operand)) else $error("zero count misbehaves");
   byte_flags_a: assert property (done && !illegal && $past(opcode[7:6]) == SIZE_BYTE |->
      condition_code_byte[CC_N] == result[7] && condition_code_byte[CC_Z] == (result[7:0] == 8'h00))
      else $error("byte N or Z wrong");
   cover property (done && writeReg);
   cover property (done && illegal);
   cover property (start ##1 start);
endmodule
bind rot_unit rot_unit_assertions u_rot_unit_assertions (.*);

// ===== dv/rot_unit_tb.sv
`timescale 1ns/1ps
module rot_unit_tb;
   import rot_pkg::*;
   typedef struct packed {logic [15:0] op; logic [31:0] opd; logic [31:0] cnt; logic [4:0] ccb; logic ill;} rot_row_t;
   logic        clk = 0, rst_b = 0, start = 0, loadEn = 0, done, illegal, writeReg;
   logic [15:0] opcode = '0;
   logic [31:0] operand = '0, loadVal = '0, countReg, result;
   logic [4:0]  ccbIn = '0, ccb;
   logic [2:0]  destReg, cntSel;
   int          num_errors = 0, checked = 0;
   rot_row_t    rows [16] = '{
      '{16'hE318, 32'h1234_5681, 32'h0, 5'h00, 1'b0}, '{16'hE05B, 32'hCAFE_8001, 32'h0, 5'h1F, 1'b0},
      '{16'hE5B5, 32'h8000_0001, 32'h41, 5'h10, 1'b0}, '{16'hEE11, 32'hFFFF_FF02, 32'h0, 5'h10, 1'b0},
      '{16'hE9BF, 32'h8765_4321, 32'h40, 5'h1F, 1'b0}, '{16'hE272, 32'h0000_8000, 32'h0, 5'h10, 1'b0},
      '{16'hE63E, 32'h0000_00A5, 32'h25, 5'h00, 1'b0}, '{16'hE7D3, 32'h0000_8001, 32'h0, 5'h00, 1'b0},
      '{16'hE4F9, 32'h0000_0001, 32'h0, 5'h00, 1'b0}, '{16'hE6F8, 32'h0000_0000, 32'h0, 5'h1F, 1'b0},
      '{16'hE7C0, 32'h1, 32'h0, 5'h0A, 1'b1}, '{16'hE7CA, 32'h1, 32'h0, 5'h15, 1'b1},
      '{16'hE7FA, 32'h1, 32'h0, 5'h1F, 1'b1}, '{16'hE108, 32'h1, 32'h0, 5'h03, 1'b1},
      '{16'hD318, 32'h1, 32'h0, 5'h11, 1'b1}, '{16'hE0D0, 32'h1, 32'h0, 5'h04, 1'b1}};
   always #2 clk = ~clk;
   rot_unit u_rot_unit (.clk(clk), .rst_b(rst_b), .start(start), .opcode(opcode), .operand(operand),
      .countReg(countReg), .ccbIn(ccbIn), .done(done), .illegal(illegal), .result(result),
      .writeReg(writeReg), .destReg(destReg), .countRegSel(cntSel), .condition_code_byte(ccb));
   rot_seq_model u_rot_seq_model (.clk(clk), .opcode(opcode), .loadEn(loadEn), .loadVal(loadVal),
      .wrEn(writeReg), .wrSel(destReg), .wrData(result), .countReg(countReg));
   // ----
   // reference rotate, one step per count: {writeReg, flags, result}
   // ----
   function automatic logic [37:0] ref_op(input rot_row_t r);
      logic [31:0] v, m;
      logic        mem, pl, x, c, b;
      int          w, n;
      mem = r.op[7:6] == SIZE_MEMORY;
      pl  = (mem ? r.op[10:9] : r.op[4:3]) == TYPE_PLAIN;
      w   = mem ? 16 : 8 << r.op[7:6];
      n   = mem ? 1 : r.op[5] ? r.cnt[5:0] : (r.op[11:9] == 0 ? 8 : r.op[11:9]);
      v   = r.opd;
      x   = r.ccb[CC_X];
      c   = pl ? 1'b0 : x;
      m   = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 1;
      for (int i = 0; i < n; i++) begin
         if (r.op[8]) begin
            b = v[w-1];
            v = {v[30:0], pl ? b : x};
         end else begin
            b = v[0];
            v = v >> 1;
            v[w-1] = pl ? b : x;
         end
         c = b;
         if (!pl) x = b;
      end
      v = (v & m) | (r.opd & ~m);
      return {!mem, x, v[w-1], (v & m) == 0, 1'b0, c, v};
   endfunction
   task automatic cmp(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic drive(input rot_row_t r);
      @(negedge clk);
      opcode = r.op;
      loadVal = r.cnt;
      loadEn = 1;
      @(negedge clk);
      loadEn = 0;
      start = 1;
      operand = r.opd;
      ccbIn = r.ccb;
   endtask
   task automatic check(input rot_row_t r);
      logic [37:0] e;
      logic [31:0] m;
      e = ref_op(r);
      m = r.op[7:6] == SIZE_MEMORY ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      cmp(done === 1'b1 && illegal === r.ill && writeReg === (e[37] & !r.ill), "handshake");
      cmp(cntSel === r.op[11:9], "count register select");
      if (r.ill) cmp(ccb === r.ccb, "flags not kept");
      else begin
         cmp(ccb === e[36:32], "flags");
         cmp((result & m) === (e[31:0] & m), "result");
         cmp(!writeReg || destReg === r.op[2:0], "destination");
      end
   endtask
   task automatic conclude;
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #1600;
      num_errors++;
      conclude();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1;
      cmp(result === RESULT_RST && ccb === CCB_RST && done === 1'b0 && cntSel === 3'h0, "reset values");
      foreach (rows[i]) begin
         drive(rows[i]);
         @(negedge clk);
         start = 0;
         check(rows[i]);
      end
      // back to back starts
      drive(rows[2]);
      @(negedge clk);
      check(rows[2]);
      opcode = rows[3].op;
      operand = rows[3].opd;
      ccbIn = rows[3].ccb;
      @(negedge clk);
      start = 0;
      check(rows[3]);
      @(negedge clk);
      cmp(done === 1'b0 && writeReg === 1'b0, "done not a pulse");
      // reset in mid-run
      rst_b = 0;
      #1 cmp(result === RESULT_RST && ccb === CCB_RST, "async reset");
      repeat (2) @(negedge clk);
      rst_b = 1;
      drive(rows[0]);
      @(negedge clk);
      start = 0;
      check(rows[0]);
      conclude();
   end
endmodule
